// >>> rtl/ttft_cfg.svh
/*
 * Constants of the thermal threshold and fetch throttle block: register
 * selects, field positions, reset values.
 * Assumes register bit 0 of the big-endian numbering is our bit 31, so
 * big-endian bit n sits at index 31-n.
 */
// Summary of operation
// - First comparison uses threshold register A
// - No interrupt: wait interval, compare other
// - Alternate until interrupt or unit disabled
// - Interrupting threshold halts, other keeps comparing
// - Both crossed: stop until threshold write
// - Crossed and valid flags are read-only
// - Unit runs in nap, doze, clocked sleep
// - Static system clock in sleep: unit inactive
// - Unthrottled: four instructions forwarded every cycle
// - Throttle only if interval nonzero and enabled
// - Forward interval bits 23-30, 0..255 clocks
// - Bit 31 enables throttling
// - Thermal gain only with dynamic power management
// - Throttling leaves clock multiplier unchanged
// - Sample interval bits 18-30 of sensor control
// - Threshold write clears valid, restarts comparison
// - Direction 0 above, 1 below threshold
// - Hard reset clears all thermal registers
`ifndef TTFT_CFG_SVH
`define TTFT_CFG_SVH

// Register selects on the special-register move port
`define TTFT_SEL_THR_A 2'h0
`define TTFT_SEL_THR_B 2'h1
`define TTFT_SEL_SENSOR 2'h2
`define TTFT_SEL_THROTTLE 2'h3

// Threshold register fields (big-endian 0,1,2-8,29,30,31)
`define TTFT_THR_CROSSED_BIT 31
`define TTFT_THR_VALID_FLAG_BIT 30
`define TTFT_THR_VALUE_MSB 29
`define TTFT_THR_VALUE_LSB 23
`define TTFT_THR_DIR_BIT 2
`define TTFT_THR_IRQ_EN_BIT 1
`define TTFT_THR_ENTRY_VALID_BIT 0

// Sensor control fields (big-endian 18-30, 31)
`define TTFT_SEN_IVL_MSB 13
`define TTFT_SEN_IVL_LSB 1
`define TTFT_SEN_ENABLE_BIT 0

// Throttle control fields (big-endian 23-30, 31)
`define TTFT_THR_FWD_MSB 8
`define TTFT_THR_FWD_LSB 1
`define TTFT_THR_EN_BIT 0

// Reset values
`define TTFT_RST_IVL 13'h0000
`define TTFT_RST_THRESH 7'h00
`define TTFT_RST_FWD 8'h00
`define TTFT_RST_WORD 32'h0000_0000

`endif

// >>> rtl/ttft_pkg.sv
/*
 * Types of the thermal threshold and fetch throttle block.
 * Assumes the constants header is included by the modules that use it.
 */
package ttft_pkg;

  // Comparison sequencer states, Gray along idle, settle, sample
  typedef enum logic [1:0] {
    TTFT_IDLE = 2'b00,
    TTFT_SETTLE = 2'b01,
    TTFT_SAMPLE = 2'b11
  } ttft_seq_t;

  typedef logic [6:0] ttft_thresh_t;
  typedef logic [12:0] ttft_ivl_t;
  typedef logic [7:0] ttft_fwd_t;

endpackage

// >>> rtl/ttft_throttle.sv
/*
 * Fetch throttle: paces cache-to-buffer forwarding by the interval field.
 * Assumes the fetch path forwards a four-instruction group on each cycle
 * in which fwd_allow is high.
 */
`timescale 1ns/100ps
`include "ttft_cfg.svh"

module ttft_throttle (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic throttle_en,
  input wire ttft_pkg::ttft_fwd_t forward_interval,
  input wire logic dynamic_power_mgmt,
  output logic fwd_allow,
  output logic thermal_reduction
);
  import ttft_pkg::*;

  ttft_fwd_t gap_reg;
  ttft_fwd_t gap_next;
  logic throttling;
  logic allow_next;

  // ****************************************
  // Pacing decode
  // ****************************************
  assign throttling = throttle_en && (forward_interval != 8'h00);
  // Idle gap of forward_interval clocks after each forwarded group
  assign allow_next = !throttling || (gap_reg == 8'h00);
  assign gap_next = !throttling ? 8'h00 :
                    (gap_reg == 8'h00) ? forward_interval : gap_reg - 8'h01;

  // Gap counter and registered outputs; clock multiplier never touched
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      gap_reg <= 8'h00;
      fwd_allow <= 1'b1;
      thermal_reduction <= 1'b0;
    end else if (clk_en) begin
      gap_reg <= gap_next;
      fwd_allow <= allow_next;
      thermal_reduction <= throttling && dynamic_power_mgmt;
    end
  end

endmodule

// >>> rtl/ttft_top.sv
/*
 * Thermal assist unit with fetch throttle: two threshold registers, sensor
 * control, throttle control, comparison sequencer and interrupt request.
 * Assumes registers are moved by a select/strobe port, the comparator
 * output is synchronous to mclk and valid once the settle count elapses.
 */
`timescale 1ns/100ps
`include "ttft_cfg.svh"

module ttft_top (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic [1:0] spr_sel,
  input wire logic spr_wr,
  input wire logic spr_rd,
  input wire logic [31:0] spr_wdata,
  output logic [31:0] spr_rdata,
  input wire logic cmp_above,
  input wire logic system_clock_input_active,
  input wire logic irq_ack,
  input wire logic dynamic_power_mgmt,
  output ttft_pkg::ttft_thresh_t dac_value,
  output logic sensor_power_on,
  output logic thermal_irq,
  output logic fwd_allow,
  output logic thermal_reduction
);
  import ttft_pkg::*;

  // ****************************************
  // Register state
  // ****************************************
  ttft_thresh_t thresh_reg [2];
  logic [1:0] dir_reg;
  logic [1:0] irq_en_reg;
  logic [1:0] entry_valid_reg;
  logic [1:0] crossed_reg;
  logic [1:0] flag_valid_reg;
  logic [1:0] halted_reg;
  ttft_ivl_t ivl_reg;
  logic sensor_en_reg;
  ttft_fwd_t fwd_reg;
  logic throttle_en_reg;
  ttft_seq_t state_reg;
  ttft_seq_t state_next;
  ttft_ivl_t count_reg;
  ttft_ivl_t count_next;
  logic sel_reg;
  logic sel_next;
  logic irq_pend_reg;

  // Field packing of a threshold register for reads
  function automatic logic [31:0] thr_word(input ttft_thresh_t th, input logic crossed,
                                           input logic fvalid, input logic dir,
                                           input logic ie, input logic ev);
    logic [31:0] w;
    w = `TTFT_RST_WORD;
    w[`TTFT_THR_CROSSED_BIT] = crossed;
    w[`TTFT_THR_VALID_FLAG_BIT] = fvalid;
    w[`TTFT_THR_VALUE_MSB:`TTFT_THR_VALUE_LSB] = th;
    w[`TTFT_THR_DIR_BIT] = dir;
    w[`TTFT_THR_IRQ_EN_BIT] = ie;
    w[`TTFT_THR_ENTRY_VALID_BIT] = ev;
    return w;
  endfunction

  // ****************************************
  // Decode
  // ****************************************
  logic [1:0] wr_thr;
  logic wr_sensor;
  logic wr_throttle;
  logic running;
  logic [1:0] eligible;
  logic sample_now;
  logic result;
  logic raise;
  logic [1:0] elig_after;
  logic [31:0] rd_word;

  // Write strobes per register
  assign wr_thr[0] = spr_wr && (spr_sel == `TTFT_SEL_THR_A);
  assign wr_thr[1] = spr_wr && (spr_sel == `TTFT_SEL_THR_B);
  assign wr_sensor = spr_wr && (spr_sel == `TTFT_SEL_SENSOR);
  assign wr_throttle = spr_wr && (spr_sel == `TTFT_SEL_THROTTLE);

  // Sequencer runs only when enabled and the system clock input toggles
  assign running = sensor_en_reg && system_clock_input_active;
  assign eligible = entry_valid_reg & ~halted_reg;
  assign sample_now = (state_reg == TTFT_SAMPLE);
  // Direction 0 flags above, 1 flags below
  assign result = dir_reg[sel_reg] ? !cmp_above : cmp_above;
  assign raise = sample_now && result && irq_en_reg[sel_reg];
  // Eligibility once this sample's halt is applied
  assign elig_after = eligible & ~({1'b0, raise} << sel_reg);

  // ****************************************
  // Comparison sequencer
  // ****************************************
  // Next state, select and settle count
  always_comb begin
    state_next = state_reg;
    sel_next = sel_reg;
    count_next = count_reg;
    case (state_reg)
      TTFT_IDLE: begin
        if (running && (eligible != 2'b00)) begin
          sel_next = !eligible[0];
          count_next = ivl_reg;
          state_next = TTFT_SETTLE;
        end
      end
      TTFT_SETTLE: begin
        if (count_reg == 13'h0000) begin
          state_next = TTFT_SAMPLE;
        end else begin
          count_next = count_reg - 13'h0001;
        end
      end
      TTFT_SAMPLE: begin
        count_next = ivl_reg;
        state_next = TTFT_SETTLE;
        if (elig_after[!sel_reg]) begin
          sel_next = !sel_reg;
        end else if (!elig_after[sel_reg]) begin
          state_next = TTFT_IDLE;
        end
      end
      default: begin
        state_next = TTFT_IDLE;
      end
    endcase
    // Disable, threshold or sensor write, or nothing eligible sends the sequencer home
    if (!running || wr_sensor || (wr_thr != 2'b00) || (eligible == 2'b00)) begin
      state_next = TTFT_IDLE;
      count_next = 13'h0000;
    end
  end

  // Sequencer registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= TTFT_IDLE;
      count_reg <= `TTFT_RST_IVL;
      sel_reg <= 1'b0;
    end else if (clk_en) begin
      state_reg <= state_next;
      count_reg <= count_next;
      sel_reg <= sel_next;
    end
  end

  // ****************************************
  // Threshold registers
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_thr
      logic hit;
      assign hit = sample_now && (sel_reg == 1'(g));
      // Software fields; flags only set by hardware
      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          thresh_reg[g] <= `TTFT_RST_THRESH;
          dir_reg[g] <= 1'b0;
          irq_en_reg[g] <= 1'b0;
          entry_valid_reg[g] <= 1'b0;
          crossed_reg[g] <= 1'b0;
          flag_valid_reg[g] <= 1'b0;
          halted_reg[g] <= 1'b0;
        end else if (clk_en) begin
          if (wr_thr[g]) begin
            thresh_reg[g] <= spr_wdata[`TTFT_THR_VALUE_MSB:`TTFT_THR_VALUE_LSB];
            dir_reg[g] <= spr_wdata[`TTFT_THR_DIR_BIT];
            irq_en_reg[g] <= spr_wdata[`TTFT_THR_IRQ_EN_BIT];
            entry_valid_reg[g] <= spr_wdata[`TTFT_THR_ENTRY_VALID_BIT];
            flag_valid_reg[g] <= 1'b0;
            halted_reg[g] <= 1'b0;
          end else if (wr_sensor) begin
            flag_valid_reg[g] <= 1'b0;
            halted_reg[g] <= 1'b0;
          end else if (hit) begin
            crossed_reg[g] <= result;
            flag_valid_reg[g] <= 1'b1;
            halted_reg[g] <= result && irq_en_reg[g];
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // Sensor control, throttle control, interrupt
  // ****************************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ivl_reg <= `TTFT_RST_IVL;
      sensor_en_reg <= 1'b0;
      fwd_reg <= `TTFT_RST_FWD;
      throttle_en_reg <= 1'b0;
    end else if (clk_en) begin
      if (wr_sensor) begin
        ivl_reg <= spr_wdata[`TTFT_SEN_IVL_MSB:`TTFT_SEN_IVL_LSB];
        sensor_en_reg <= spr_wdata[`TTFT_SEN_ENABLE_BIT];
      end
      if (wr_throttle) begin
        fwd_reg <= spr_wdata[`TTFT_THR_FWD_MSB:`TTFT_THR_FWD_LSB];
        throttle_en_reg <= spr_wdata[`TTFT_THR_EN_BIT];
      end
    end
  end

  // Held request; a new crossing wins over the acknowledge
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irq_pend_reg <= 1'b0;
    end else if (clk_en) begin
      irq_pend_reg <= raise || (irq_pend_reg && !irq_ack);
    end
  end

  // ****************************************
  // Read data and analog side outputs
  // ****************************************
  assign rd_word =
    (spr_sel == `TTFT_SEL_THR_A) ? thr_word(thresh_reg[0], crossed_reg[0],
      flag_valid_reg[0], dir_reg[0], irq_en_reg[0], entry_valid_reg[0]) :
    (spr_sel == `TTFT_SEL_THR_B) ? thr_word(thresh_reg[1], crossed_reg[1],
      flag_valid_reg[1], dir_reg[1], irq_en_reg[1], entry_valid_reg[1]) :
    (spr_sel == `TTFT_SEL_SENSOR) ? {18'h00000, ivl_reg, sensor_en_reg} :
    {23'h000000, fwd_reg, throttle_en_reg};

  // Registered read port and analog drive
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      spr_rdata <= `TTFT_RST_WORD;
      dac_value <= `TTFT_RST_THRESH;
      sensor_power_on <= 1'b0;
      thermal_irq <= 1'b0;
    end else if (clk_en) begin
      if (spr_rd) begin
        spr_rdata <= rd_word;
      end
      dac_value <= thresh_reg[sel_next];
      sensor_power_on <= (state_next != TTFT_IDLE);
      thermal_irq <= raise || (irq_pend_reg && !irq_ack);
    end
  end

  // ****************************************
  // Fetch throttle
  // ****************************************
  ttft_throttle u_throttle (
    .mclk(mclk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .throttle_en(throttle_en_reg),
    .forward_interval(fwd_reg),
    .dynamic_power_mgmt(dynamic_power_mgmt),
    .fwd_allow(fwd_allow),
    .thermal_reduction(thermal_reduction)
  );

endmodule

// >>> sim/ttft_sensor_model.sv
/* Comparator and interrupt unit beside ttft_top.
   Assumes the bench sets temperature and acknowledge delay. */
`timescale 1ns/100ps
module ttft_sensor_model (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [6:0] temp,
  input wire ttft_pkg::ttft_thresh_t dac_value,
  input wire logic sensor_power_on,
  input wire logic thermal_irq,
  input wire logic [3:0] ack_wait,
  output logic cmp_above,
  output logic irq_ack
);
  import ttft_pkg::*;
  // ****
  // Comparator and acknowledge
  // ****
  logic [3:0] wait_cnt;
  logic noise_reg;
  // Unpowered comparator output wanders
  assign cmp_above = sensor_power_on ? temp > dac_value : noise_reg;
  assign irq_ack = thermal_irq && wait_cnt == ack_wait;
  // Recognition after ack_wait cycles
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wait_cnt <= 4'h0;
      noise_reg <= 1'b0;
    end else begin
      noise_reg <= !noise_reg;
      wait_cnt <= (thermal_irq && !irq_ack) ? wait_cnt + 4'h1 : 4'h0;
    end
  end
endmodule

// >>> sim/ttft_top_props.sv
/* Port checker of the thermal unit and fetch throttle.
   Assumes binding to ttft_top, one clock, async active-low reset. */
`timescale 1ns/100ps
module ttft_props (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic [1:0] spr_sel,
  input wire logic spr_wr,
  input wire logic spr_rd,
  input wire logic [31:0] spr_wdata,
  input wire logic [31:0] spr_rdata,
  input wire logic system_clock_input_active,
  input wire logic dynamic_power_mgmt,
  input wire logic sensor_power_on,
  input wire logic thermal_irq,
  input wire logic fwd_allow,
  input wire logic thermal_reduction
);
  // ****
  // Throttle tracking
  // ****
  logic wr_thr, thr_off, clean;
  logic [7:0] fwd_q;
  logic [8:0] low_cnt;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  assign wr_thr = clk_en && spr_wr && spr_sel == 2'h3;
  // Last throttle word and length of the current low run
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      thr_off <= 1'b1;
      fwd_q <= 8'h00;
      clean <= 1'b0;
      low_cnt <= 9'h000;
    end else begin
      if (wr_thr) begin
        thr_off <= !spr_wdata[0] || spr_wdata[8:1] == 8'h00;
        fwd_q <= spr_wdata[8:1];
      end
      // Run counts only if its gap load came after the last write
      clean <= !wr_thr && (clean || ($fell(fwd_allow) && !$past(wr_thr) && !$past(wr_thr, 2)));
      if (clk_en) begin
        low_cnt <= fwd_allow ? 9'h000 : low_cnt + 9'h001;
      end
    end
  end
  sequence s_sensor_off;
    clk_en && spr_wr && spr_sel == 2'h2 && !spr_wdata[0];
  endsequence
  property p_reset_vals;
    $rose(arst_n) |-> fwd_allow && !thermal_irq && !sensor_power_on && spr_rdata == 32'h0;
  endproperty
  property p_sensor_off;
    s_sensor_off |-> ##[1:2] !sensor_power_on;
  endproperty
  property p_idle_quiet;
    !sensor_power_on [*4] |=> !$rose(thermal_irq);
  endproperty
  property p_rdata_hold;
    !(clk_en && spr_rd) |=> $stable(spr_rdata);
  endproperty
  property p_clk_stop;
    clk_en && !system_clock_input_active |-> ##[1:2] !sensor_power_on;
  endproperty
  property p_dpm_gate;
    clk_en && !dynamic_power_mgmt |=> !thermal_reduction;
  endproperty
  property p_thr_off;
    thr_off [*3] |-> fwd_allow && !thermal_reduction;
  endproperty
  property p_fi_gap;
    clean && $rose(fwd_allow) |-> low_cnt == {1'b0, fwd_q};
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values");
  a_sensor_off: assert property (p_sensor_off) else $error("still on");
  a_idle_quiet: assert property (p_idle_quiet) else $error("idle irq");
  a_rdata_hold: assert property (p_rdata_hold) else $error("rdata moved");
  a_clk_stop: assert property (p_clk_stop) else $error("active");
  a_dpm_gate: assert property (p_dpm_gate) else $error("reduction");
  a_thr_off: assert property (p_thr_off) else $error("throttled");
  a_fi_gap: assert property (p_fi_gap) else $error("gap length");
endmodule

bind ttft_top ttft_props u_props (
  .mclk(mclk),
  .arst_n(arst_n),
  .clk_en(clk_en),
  .spr_sel(spr_sel),
  .spr_wr(spr_wr),
  .spr_rd(spr_rd),
  .spr_wdata(spr_wdata),
  .spr_rdata(spr_rdata),
  .system_clock_input_active(system_clock_input_active),
  .dynamic_power_mgmt(dynamic_power_mgmt),
  .sensor_power_on(sensor_power_on),
  .thermal_irq(thermal_irq),
  .fwd_allow(fwd_allow),
  .thermal_reduction(thermal_reduction)
);

// >>> sim/ttft_top_tb.sv
/* Bench for ttft_top: register moves, sequencing, throttle.
   Assumes the sensor model drives comparator and acknowledge. */
`timescale 1ns/100ps
module ttft_top_tb;
  import ttft_pkg::*;
  // ****
  // Stimulus and checks
  // ****
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic clk_en = 1'b1;
  logic spr_wr = 1'b0;
  logic spr_rd = 1'b0;
  logic [1:0] spr_sel = 2'h0;
  logic [31:0] spr_wdata = 32'h0, spr_rdata, rv;
  logic system_clock_input_active = 1'b1;
  logic dynamic_power_mgmt = 1'b0;
  logic cmp_above, irq_ack, sensor_power_on, thermal_irq, fwd_allow, thermal_reduction;
  ttft_thresh_t dac_value;
  logic [6:0] temp = 7'h32;
  logic [3:0] ack_wait = 4'h2;
  int num_errors = 0, compares = 0, cyc = 0, n, m;
  logic [6:0] tt [4] = '{7'h3C, 7'h50, 7'h3C, 7'h50};
  logic [3:0] dd [4] = '{4'h5, 4'hD, 4'h9, 4'h1};
  logic [9:0] tp [5] = '{10'h20B, 10'h3FF, 10'h201, 10'h20A, 10'h00B};
  wire [1:0] mon = {thermal_irq, sensor_power_on};
  always #20 mclk = ~mclk;
  ttft_top u_dut (
    .mclk(mclk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .spr_sel(spr_sel),
    .spr_wr(spr_wr),
    .spr_rd(spr_rd),
    .spr_wdata(spr_wdata),
    .spr_rdata(spr_rdata),
    .cmp_above(cmp_above),
    .system_clock_input_active(system_clock_input_active),
    .irq_ack(irq_ack),
    .dynamic_power_mgmt(dynamic_power_mgmt),
    .dac_value(dac_value),
    .sensor_power_on(sensor_power_on),
    .thermal_irq(thermal_irq),
    .fwd_allow(fwd_allow),
    .thermal_reduction(thermal_reduction)
  );
  ttft_sensor_model u_model (
    .mclk(mclk),
    .arst_n(arst_n),
    .temp(temp),
    .dac_value(dac_value),
    .sensor_power_on(sensor_power_on),
    .thermal_irq(thermal_irq),
    .ack_wait(ack_wait),
    .cmp_above(cmp_above),
    .irq_ack(irq_ack)
  );
  function automatic logic [31:0] thw(input logic [6:0] t, input logic [2:0] c);
    return {2'h0, t, 20'h0, c};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic tick();
    @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [1:0] s, input logic [31:0] d);
    @(posedge mclk);
    spr_sel <= s;
    spr_wdata <= d;
    spr_wr <= 1'b1;
    @(posedge mclk);
    spr_wr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] s);
    @(posedge mclk);
    spr_sel <= s;
    spr_rd <= 1'b1;
    @(posedge mclk);
    spr_rd <= 1'b0;
    #1 rv = spr_rdata;
  endtask
  task automatic wt(input int b, input logic v);
    for (int k = 0; k < 600 && mon[b] !== v; k++) tick();
    chk(mon[b], v, "wait");
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      num_errors++;
      results();
    end
  end
  // Test sequence
  initial begin
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      rd(s[1:0]);
      chk(rv, 32'h0, "reset");
    end
    chk(fwd_allow, 1'b1, "fwd");
    wr(2'h0, thw(7'h3C, 3'h0) | 32'hC000_0000);
    rd(2'h0);
    chk(rv, thw(7'h3C, 3'h0), "ro flags");
    $display("test reset done");
    wr(2'h0, thw(7'h3C, 3'h3));
    wr(2'h1, thw(7'h28, 3'h3));
    wr(2'h2, 32'h0000_0029);
    wt(0, 1'b1);
    tick();
    chk(dac_value, 7'h3C, "first");
    wt(1, 1'b1);
    rd(2'h0);
    chk(rv, thw(7'h3C, 3'h3) | 32'h4000_0000, "A flags");
    rd(2'h1);
    chk(rv, thw(7'h28, 3'h3) | 32'hC000_0000, "B flags");
    wt(1, 1'b0);
    repeat (60) tick();
    chk({sensor_power_on, dac_value}, {1'b1, 7'h3C}, "A only");
    @(posedge mclk);
    temp <= 7'h46;
    wt(1, 1'b1);
    wt(1, 1'b0);
    repeat (5) tick();
    chk(sensor_power_on, 1'b0, "both");
    wr(2'h0, thw(7'h50, 3'h3));
    rd(2'h0);
    // Write clears valid only; crossed keeps the last crossing
    chk(rv, thw(7'h50, 3'h3) | 32'h8000_0000, "rewrite");
    wt(0, 1'b1);
    $display("test dual done");
    wr(2'h1, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(2'h0, thw(tt[i], dd[i][2:0]));
      rv = 32'h0;
      for (int k = 0; k < 40 && rv[30] !== 1'b1; k++) rd(2'h0);
      chk(rv, thw(tt[i], dd[i][2:0]) | {dd[i][3], 31'h4000_0000}, "measure");
    end
    chk(thermal_irq, 1'b0, "quiet");
    @(posedge mclk);
    system_clock_input_active <= 1'b0;
    repeat (3) tick();
    chk(sensor_power_on, 1'b0, "static");
    @(posedge mclk);
    system_clock_input_active <= 1'b1;
    wt(0, 1'b1);
    wr(2'h2, 32'h0000_0028);
    repeat (3) tick();
    chk(sensor_power_on, 1'b0, "disable");
    $display("test measure done");
    for (int i = 0; i < 5; i++) begin
      wr(2'h3, {23'h0, tp[i][8:0]});
      dynamic_power_mgmt <= tp[i][9];
      rd(2'h3);
      chk(rv, {23'h0, tp[i][8:0]}, "throttle reg");
      for (m = 0; m < 300 && fwd_allow === 1'b0; m++) tick();
      for (m = 0; m < 300 && fwd_allow === 1'b1; m++) tick();
      for (n = 0; n < 300 && fwd_allow === 1'b0; n++) tick();
      chk(n, (tp[i][0] && tp[i][8:1] != 8'h00) ? tp[i][8:1] : 8'h00, "gap");
      chk(thermal_reduction, tp[i][9] && tp[i][0] && tp[i][8:1] != 8'h00, "red");
      // Clock enable low: pacing must freeze
      if (i == 0) begin
        @(posedge mclk);
        clk_en <= 1'b0;
        tick();
        rv[0] = fwd_allow;
        for (int k = 0; k < 13; k++) begin
          tick();
          chk(fwd_allow, rv[0], "frozen");
        end
        @(posedge mclk);
        clk_en <= 1'b1;
      end
      wr(2'h3, 32'h0);
    end
    $display("test throttle done");
    results();
  end
endmodule
